// ---- hdl/ifr_consts.vh ----
// Purpose: Shared constants of the image formatting path (offsets, fields, resets, codes)
// Assumes: Included by bare name by the top design file only; the frame store does not include it
// Notes: Register offsets are byte addresses on the APB bus, one 32-bit word each
`ifndef IFR_CONSTS_VH
`define IFR_CONSTS_VH

// Register byte offsets
`define IFR_OFF_CTRL 8'h00
`define IFR_OFF_PATTERN 8'h04
`define IFR_OFF_LEFT 8'h08
`define IFR_OFF_TOP 8'h0c
`define IFR_OFF_WIDTH 8'h10
`define IFR_OFF_HEIGHT 8'h14
`define IFR_OFF_MAXSIZE 8'h18
`define IFR_OFF_MOSAIC 8'h1c

// Control register fields
`define IFR_CTRL_REVX 0
`define IFR_CTRL_REVY 1
`define IFR_CTRL_SRCSEL 2
`define IFR_CTRL_DEPTH_LO 4
`define IFR_CTRL_DEPTH_HI 5
`define IFR_CTRL_PW_LO 8
`define IFR_CTRL_PW_HI 12

// Reset values
`define IFR_RST_DEPTH 2'h1
`define IFR_RST_PW 5'h10
`define IFR_RST_SIZE 16'hffff

// Converter depth codes and their left-alignment shift amounts
`define IFR_DEPTH_10 2'h0
`define IFR_DEPTH_12 2'h1
`define IFR_DEPTH_14 2'h2
`define IFR_SHIFT_10 4'h6
`define IFR_SHIFT_12 4'h4
`define IFR_SHIFT_14 4'h2
`define IFR_WORD_BITS 5'h10

// Pattern source and pattern choice codes
`define IFR_SRC_SENSOR 1'b0
`define IFR_SRC_PIPE 1'b1
`define IFR_PAT_OFF 2'h0
`define IFR_PAT_SENSOR 2'h1
`define IFR_PAT_INC 2'h2

// Mosaic phase codes: bit 0 swaps columns, bit 1 swaps rows
`define IFR_MOS_RG 2'h0
`define IFR_MOS_GR 2'h1
`define IFR_MOS_GB 2'h2
`define IFR_MOS_BG 2'h3

// Colour conversion, coefficients scaled by 256
`define IFR_KY_R 18'h0004d
`define IFR_KY_G 18'h00096
`define IFR_KY_B 18'h0001d
`define IFR_KCB_R 18'h0002b
`define IFR_KCB_G 18'h00055
`define IFR_KCB_B 18'h00080
`define IFR_KCR_R 18'h00080
`define IFR_KCR_G 18'h0006b
`define IFR_KCR_B 18'h00015
`define IFR_C_OFFS 18'h08080
`define IFR_CHROMA_GROUP 2'h3

`endif

// ---- hdl/ifr_frame_mem.v ----
// Purpose: Single frame store with one write port and one registered read port
// Assumes: Same clock for both ports; read data appears one edge after the address
// Notes: No reset on the array; contents are only read after being written
`timescale 1ns/1ps
`default_nettype none
module ifr_frame_mem #(
  parameter DW = 16,
  parameter AW = 8
) (
  input wire pclk, // Clock
  input wire wr_en, // Write strobe
  input wire [AW-1:0] wr_addr, // Write address
  input wire [DW-1:0] wr_data, // Write data
  input wire [AW-1:0] rd_addr, // Read address
  output reg [DW-1:0] rd_data // Read data, registered
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Write and registered read; read of the address being written returns old data
  always @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ---- hdl/ifr_format_top.v ----
// Purpose: Image formatting path: bit alignment, test patterns, mirroring, window crop,
//   and an RGB to luma/chroma converter with quarter-rate chroma
// Assumes: Sensor stream and APB share pclk; a frame ends with in_eof on its last pixel
// Notes: Whole frame is stored before readout, so input stalls during readout
// Overview of operation
// - Quarter format keeps every luma, one chroma per four pixels, all lines.
// - Conversion maps 0..255 RGB onto full 0..255 luma and 1..255 chroma.
// - Narrower pixel width drops surplus low bits of each sample.
// - Wider pixel width pads missing low bits with ignorable zeros.
// - Samples sit left-aligned in a 16-bit word, e.g. 12 bits masks 0xFFF0.
// - Converter depths 10, 12 and 14 bits, scaled into the 16-bit range.
// - Source selector picks which pattern generator is being configured.
// - Off disables selected generator; sensor choice enables only the sensor one, increment only the pipeline one.
// - Increment pattern adds one grey step per pixel, wrapping after 255.
// - With both generators on, pipeline pattern replaces sensor pattern.
// - Later processing alters patterns; exposure, gain, black level do not.
// - Real sensor pixels pass only with both generators off.
// - Only pixels inside the offset/width/height window are passed on.
// - Window width is limited to line width minus horizontal offset.
// - Window height is limited to frame height minus vertical offset.
// - Horizontal mirror reverses pixels in a line, crop applied afterwards.
// - Horizontal mirror swaps mosaic columns, red-green becomes green-red.
// - Vertical mirror reverses lines in a frame, crop applied afterwards.
// - Vertical mirror swaps mosaic rows, red-green becomes green-blue.
`timescale 1ns/1ps
`default_nettype none
`include "ifr_consts.vh"
module ifr_format_top #(
  parameter XB = 4, // Address bits for a column, max line is 2**XB pixels
  parameter YB = 4 // Address bits for a line, max frame is 2**YB lines
) (
  input wire pclk, // Clock, 10 MHz
  input wire presetn, // Asynchronous reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output reg pslverr, // APB error on unmapped address
  input wire in_valid, // Sensor sample valid
  output wire in_ready, // Block accepts a sample
  input wire [13:0] in_data, // Converter code, right-justified
  input wire in_sof, // First pixel of frame
  input wire in_eol, // Last pixel of line
  input wire in_eof, // Last pixel of frame
  output reg out_valid, // Output pixel valid
  output wire [15:0] out_data, // Left-aligned output pixel
  output reg out_sof, // First pixel of output frame
  output reg out_eol, // Last pixel of output line
  output reg out_eof, // Last pixel of output frame
  input wire rgb_valid, // Colour pixel valid
  input wire rgb_sol, // First colour pixel of a line
  input wire [7:0] rgb_r, // Red
  input wire [7:0] rgb_g, // Green
  input wire [7:0] rgb_b, // Blue
  output reg yc_valid, // Luma valid, every pixel
  output reg yc_chroma_valid, // Chroma valid, first pixel of each group of four
  output reg [7:0] yc_y, // Luma
  output reg [7:0] yc_cb, // Blue difference chroma
  output reg [7:0] yc_cr // Red difference chroma
);
  localparam ST_CAPT = 2'b00;
  localparam ST_SIZE = 2'b01;
  localparam ST_READ = 2'b10;
  localparam [15:0] MAX_W = 16'h0001 << XB;
  localparam [15:0] MAX_H = 16'h0001 << YB;

  reg [15:0] ctrl_q;
  reg sens_en_q;
  reg pipe_en_q;
  reg [15:0] left_q;
  reg [15:0] top_q;
  reg [15:0] width_q;
  reg [15:0] height_q;
  reg [1:0] mos_base_q;
  reg [1:0] depth_q;
  reg [1:0] state_q;
  reg [15:0] in_x_q;
  reg [15:0] in_y_q;
  reg [7:0] inc_q;
  reg [15:0] fw_q;
  reg [15:0] fh_q;
  reg [15:0] ew_q;
  reg [15:0] eh_q;
  reg [15:0] ox_q;
  reg [15:0] oy_q;
  reg [1:0] grp_q;

  wire rev_x = ctrl_q[`IFR_CTRL_REVX];
  wire rev_y = ctrl_q[`IFR_CTRL_REVY];
  wire src_sel = ctrl_q[`IFR_CTRL_SRCSEL];
  wire [4:0] pix_w = ctrl_q[`IFR_CTRL_PW_HI:`IFR_CTRL_PW_LO];
  wire [1:0] mos_phase = mos_base_q ^ {rev_y, rev_x};

  // APB: zero wait states, read data and error captured in the setup cycle
  wire setup = psel & ~penable;
  wire wr_acc = psel & penable & pwrite;
  assign pready = 1'b1;

  reg [31:0] rd_mux;
  reg rd_hit;
  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `IFR_OFF_CTRL: rd_mux = {16'h0000, ctrl_q};
      `IFR_OFF_PATTERN: begin
        if (src_sel == `IFR_SRC_PIPE) begin
          rd_mux = {30'h0000_0000, pipe_en_q ? `IFR_PAT_INC : `IFR_PAT_OFF};
        end else begin
          rd_mux = {30'h0000_0000, sens_en_q ? `IFR_PAT_SENSOR : `IFR_PAT_OFF};
        end
      end
      `IFR_OFF_LEFT: rd_mux = {16'h0000, left_q};
      `IFR_OFF_TOP: rd_mux = {16'h0000, top_q};
      `IFR_OFF_WIDTH: rd_mux = {16'h0000, width_q};
      `IFR_OFF_HEIGHT: rd_mux = {16'h0000, height_q};
      `IFR_OFF_MAXSIZE: rd_mux = {fh_q, fw_q};
      `IFR_OFF_MOSAIC: rd_mux = {26'h0000_000, mos_phase, 2'h0, mos_base_q};
      default: rd_hit = 1'b0;
    endcase
  end

  // Read data held from setup through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~rd_hit;
    end
  end

  // Register writes; the pattern word acts on the generator named by the selector
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= {3'h0, `IFR_RST_PW, 2'h0, `IFR_RST_DEPTH, 4'h0};
      sens_en_q <= 1'b0;
      pipe_en_q <= 1'b0;
      left_q <= 16'h0000;
      top_q <= 16'h0000;
      width_q <= `IFR_RST_SIZE;
      height_q <= `IFR_RST_SIZE;
      mos_base_q <= `IFR_MOS_RG;
    end else if (wr_acc) begin
      case (paddr)
        `IFR_OFF_CTRL: ctrl_q <= pwdata[15:0];
        `IFR_OFF_PATTERN: begin
          if (src_sel == `IFR_SRC_SENSOR) begin
            if (pwdata[1:0] == `IFR_PAT_OFF) begin
              sens_en_q <= 1'b0;
            end else if (pwdata[1:0] == `IFR_PAT_SENSOR) begin
              sens_en_q <= 1'b1;
            end
          end else begin
            if (pwdata[1:0] == `IFR_PAT_OFF) begin
              pipe_en_q <= 1'b0;
            end else if (pwdata[1:0] == `IFR_PAT_INC) begin
              pipe_en_q <= 1'b1;
            end
          end
        end
        `IFR_OFF_LEFT: left_q <= pwdata[15:0];
        `IFR_OFF_TOP: top_q <= pwdata[15:0];
        `IFR_OFF_WIDTH: width_q <= pwdata[15:0];
        `IFR_OFF_HEIGHT: height_q <= pwdata[15:0];
        `IFR_OFF_MOSAIC: mos_base_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Input position; a frame-start pixel restarts the counts at the origin
  wire acc = in_valid & in_ready;
  wire [15:0] cur_x = in_sof ? 16'h0000 : in_x_q;
  wire [15:0] cur_y = in_sof ? 16'h0000 : in_y_q;
  wire [7:0] cur_inc = in_sof ? 8'h00 : inc_q;
  // Depth taken only at frame start, so a change never splits a frame
  wire [1:0] depth_use = in_sof ? ctrl_q[`IFR_CTRL_DEPTH_HI:`IFR_CTRL_DEPTH_LO] : depth_q;
  assign in_ready = (state_q == ST_CAPT);

  // Sensor pattern replaces the converter code; exposure and gain never reach it
  wire [15:0] xy_sum = cur_x + cur_y;
  wire [13:0] raw = sens_en_q ? xy_sum[13:0] : in_data;

  // Left-align the converter code into 16 bits
  reg [3:0] shamt;
  always @* begin
    case (depth_use)
      `IFR_DEPTH_10: shamt = `IFR_SHIFT_10;
      `IFR_DEPTH_12: shamt = `IFR_SHIFT_12;
      default: shamt = `IFR_SHIFT_14;
    endcase
  end
  wire [29:0] wide = {16'h0000, raw} << shamt;
  wire [15:0] aligned = wide[15:0];
  // Shifting in zeros pads a wide format; the mask drops bits a narrow one lacks
  wire [4:0] drop = `IFR_WORD_BITS - pix_w;
  wire [15:0] keep_mask = 16'hffff << drop;
  wire [15:0] formatted = aligned & keep_mask;
  // Pipeline pattern enters after alignment and wins over the sensor pattern
  wire [15:0] stage_pix = pipe_en_q ? {cur_inc, 8'h00} : formatted;

  wire wr_en = acc & (cur_x < MAX_W) & (cur_y < MAX_H);
  wire [XB+YB-1:0] wr_addr = {cur_y[YB-1:0], cur_x[XB-1:0]};

  // Window limits: width at most line width minus offset, height likewise
  wire [15:0] room_w = (left_q < fw_q) ? (fw_q - left_q) : 16'h0000;
  wire [15:0] room_h = (top_q < fh_q) ? (fh_q - top_q) : 16'h0000;
  wire [15:0] lim_w = (width_q < room_w) ? width_q : room_w;
  wire [15:0] lim_h = (height_q < room_h) ? height_q : room_h;

  // Readout: crop in mirrored coordinates, then map back to the stored frame
  wire [15:0] mx = left_q + ox_q;
  wire [15:0] my = top_q + oy_q;
  wire [15:0] sx = rev_x ? (fw_q - 16'h0001 - mx) : mx;
  wire [15:0] sy = rev_y ? (fh_q - 16'h0001 - my) : my;
  wire [XB+YB-1:0] rd_addr = {sy[YB-1:0], sx[XB-1:0]};
  wire last_x = (ox_q == ew_q - 16'h0001);
  wire last_y = (oy_q == eh_q - 16'h0001);

  // Capture, size and readout sequence
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_CAPT;
      in_x_q <= 16'h0000;
      in_y_q <= 16'h0000;
      inc_q <= 8'h00;
      depth_q <= `IFR_RST_DEPTH;
      fw_q <= 16'h0000;
      fh_q <= 16'h0000;
      ew_q <= 16'h0000;
      eh_q <= 16'h0000;
      ox_q <= 16'h0000;
      oy_q <= 16'h0000;
      out_valid <= 1'b0;
      out_sof <= 1'b0;
      out_eol <= 1'b0;
      out_eof <= 1'b0;
    end else begin
      out_valid <= 1'b0;
      out_sof <= 1'b0;
      out_eol <= 1'b0;
      out_eof <= 1'b0;
      case (state_q)
        ST_CAPT: begin
          if (acc) begin
            depth_q <= depth_use;
            inc_q <= cur_inc + 8'h01;
            if (in_eol | in_eof) begin
              in_x_q <= 16'h0000;
              in_y_q <= cur_y + 16'h0001;
              fw_q <= (cur_x < MAX_W) ? (cur_x + 16'h0001) : MAX_W;
            end else begin
              in_x_q <= cur_x + 16'h0001;
              in_y_q <= cur_y;
            end
            if (in_eof) begin
              fh_q <= (cur_y < MAX_H) ? (cur_y + 16'h0001) : MAX_H;
              state_q <= ST_SIZE;
            end
          end
        end
        ST_SIZE: begin
          ew_q <= lim_w;
          eh_q <= lim_h;
          ox_q <= 16'h0000;
          oy_q <= 16'h0000;
          state_q <= ((lim_w == 16'h0000) || (lim_h == 16'h0000)) ? ST_CAPT : ST_READ;
        end
        ST_READ: begin
          out_valid <= 1'b1;
          out_sof <= (ox_q == 16'h0000) && (oy_q == 16'h0000);
          out_eol <= last_x;
          out_eof <= last_x & last_y;
          if (last_x) begin
            ox_q <= 16'h0000;
            oy_q <= oy_q + 16'h0001;
            if (last_y) begin
              state_q <= ST_CAPT;
            end
          end else begin
            ox_q <= ox_q + 16'h0001;
          end
        end
        default: state_q <= ST_CAPT;
      endcase
    end
  end

  // Frame store; its registered read lines up with the delayed markers above
  ifr_frame_mem #(
    .DW(16),
    .AW(XB + YB)
  ) u_mem (
    .pclk(pclk),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(stage_pix),
    .rd_addr(rd_addr),
    .rd_data(out_data)
  );

  // Colour conversion with 8 fraction bits; offsets folded in so no sign handling
  wire [17:0] r18 = {10'h000, rgb_r};
  wire [17:0] g18 = {10'h000, rgb_g};
  wire [17:0] b18 = {10'h000, rgb_b};
  wire [17:0] y_sum = `IFR_KY_R * r18 + `IFR_KY_G * g18 + `IFR_KY_B * b18;
  wire [17:0] cb_pos = `IFR_C_OFFS + `IFR_KCB_B * b18;
  wire [17:0] cb_neg = `IFR_KCB_R * r18 + `IFR_KCB_G * g18;
  wire [17:0] cr_pos = `IFR_C_OFFS + `IFR_KCR_R * r18;
  wire [17:0] cr_neg = `IFR_KCR_G * g18 + `IFR_KCR_B * b18;
  wire [17:0] cb_sum = cb_pos - cb_neg;
  wire [17:0] cr_sum = cr_pos - cr_neg;
  // Saturate at 255 so extreme inputs still reach full scale
  wire [7:0] cb_sat = (cb_sum[17:8] > 10'h0ff) ? 8'hff : cb_sum[15:8];
  wire [7:0] cr_sat = (cr_sum[17:8] > 10'h0ff) ? 8'hff : cr_sum[15:8];
  wire [1:0] grp = rgb_sol ? 2'h0 : grp_q;

  // Luma every pixel, chroma once per group of four, every line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grp_q <= 2'h0;
      yc_valid <= 1'b0;
      yc_chroma_valid <= 1'b0;
      yc_y <= 8'h00;
      yc_cb <= 8'h00;
      yc_cr <= 8'h00;
    end else begin
      yc_valid <= rgb_valid;
      yc_chroma_valid <= rgb_valid & (grp == 2'h0);
      if (rgb_valid) begin
        grp_q <= (grp == `IFR_CHROMA_GROUP) ? 2'h0 : grp + 2'h1;
        yc_y <= y_sum[15:8];
        if (grp == 2'h0) begin
          yc_cb <= cb_sat;
          yc_cr <= cr_sat;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/ifr_format_chk.sv ----
// Purpose: Port-level timing checks of the image formatting path
// Assumes: One clock pclk, asynchronous active-low presetn
// Notes: Pixel values are judged by the bench; here only relations in time
`timescale 1ns/1ps
`default_nettype none
module ifr_format_chk (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic [7:0] paddr, // APB address
  input wire logic pslverr, // APB error
  input wire logic in_valid, // Sample valid
  input wire logic in_ready, // Sample taken
  input wire logic in_eof, // Last input pixel
  input wire logic out_valid, // Output valid
  input wire logic out_sof, // Output frame start
  input wire logic out_eof, // Output frame end
  input wire logic rgb_valid, // Colour valid
  input wire logic rgb_sol, // Colour line start
  input wire logic yc_valid, // Luma valid
  input wire logic yc_chroma_valid // Chroma valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Error is loaded at the setup edge, so it must show in the access phase
  unmapped_err_a: assert property (psel && !penable && paddr > 8'h1c |=> pslverr)
    else $error("no error on unmapped address");
  luma_each_a: assert property (rgb_valid |=> yc_valid)
    else $error("luma missing");
  luma_none_a: assert property (!rgb_valid |=> !yc_valid)
    else $error("luma without input");
  chroma_first_a: assert property (rgb_valid && rgb_sol |=> yc_chroma_valid)
    else $error("chroma missing at line start");
  chroma_skip_a: assert property (rgb_valid && rgb_sol ##1 rgb_valid && !rgb_sol
    |=> !yc_chroma_valid)
    else $error("chroma on second pixel");
  chroma_fifth_a: assert property (rgb_valid && rgb_sol ##1 (rgb_valid && !rgb_sol) [*4]
    |=> yc_chroma_valid)
    else $error("chroma missing on fifth pixel");
  // Whole frame is stored first, so capture must stop after the last pixel
  frame_hold_a: assert property (in_valid && in_ready && in_eof |=> !in_ready)
    else $error("capture continues after frame end");
  // Capture reopens at the edge that issues the last pixel, so look one cycle back
  readout_stall_a: assert property (out_valid |-> !$past(in_ready))
    else $error("capture during readout");
  marks_valid_a: assert property (out_sof || out_eof |-> out_valid)
    else $error("frame mark without pixel");
  cover property (out_sof);
  cover property (pslverr);
  cover property (yc_chroma_valid);
endmodule
bind ifr_format_top ifr_format_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pslverr(pslverr), .in_valid(in_valid),
  .in_ready(in_ready), .in_eof(in_eof), .out_valid(out_valid), .out_sof(out_sof),
  .out_eof(out_eof), .rgb_valid(rgb_valid), .rgb_sol(rgb_sol), .yc_valid(yc_valid),
  .yc_chroma_valid(yc_chroma_valid));
`default_nettype wire

// ---- tb/ifr_sensor_model.sv ----
// Purpose: Behavioural sensor converter sending one frame per start pulse
// Assumes: Codes right-justified in 14 bits; geometry is set before start
// Notes: Released data shows the inverted last code so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module ifr_sensor_model (
  input wire logic pclk, // Clock
  input wire logic start, // Send one frame
  input wire logic [4:0] fw, // Pixels per line
  input wire logic [4:0] fh, // Lines per frame
  input wire logic [13:0] base, // Code of the first pixel
  input wire logic in_ready, // Block takes the sample
  output logic in_valid, // Sample valid
  output logic [13:0] in_data, // Sample code
  output logic in_sof, // First pixel
  output logic in_eol, // Line end
  output logic in_eof, // Frame end
  output logic busy // Frame in progress
);
  logic rdy;
  int x, y;
  // Ready copied mid-cycle so the edge decision never races the block
  always @(negedge pclk) rdy <= in_ready;
  // Frames only on request, so settings change while acquisition is halted
  initial begin
    in_valid = 0; in_data = 14'h3fff; in_sof = 0; in_eol = 0; in_eof = 0; busy = 0;
    forever begin
      @(posedge pclk);
      if (start) begin
        busy <= 1;
        for (y = 0; y < fh; y++)
          for (x = 0; x < fw; x++) begin
            in_valid <= 1;
            in_data <= base + 14'(y * 16 + x);
            in_sof <= (x == 0 && y == 0);
            in_eol <= (x == fw - 1);
            in_eof <= (x == fw - 1 && y == fh - 1);
            do @(posedge pclk); while (!rdy);
          end
        in_valid <= 0; in_data <= ~in_data; in_sof <= 0; in_eol <= 0; in_eof <= 0;
        busy <= 0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/image_format_roi_pipeline_test.sv ----
// Purpose: Self-checking bench of the image formatting path
// Assumes: Zero-wait APB; frames of 5x3 pixels through a 3x2 window, the last through an empty one
// Notes: Drivers queue expected results; a mid-cycle monitor pops and compares
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module image_format_roi_pipeline_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, in_valid, in_ready, in_sof;
  logic in_eol, in_eof, out_valid, out_sof, out_eol, out_eof, rgb_valid, rgb_sol;
  logic yc_valid, yc_chroma_valid, start, busy;
  logic [7:0] paddr, rgb_r, rgb_g, rgb_b, yc_y, yc_cb, yc_cr;
  logic [31:0] pwdata, prdata;
  logic [13:0] in_data, base;
  logic [15:0] out_data, v;
  logic [4:0] fw, fh;
  logic [32:0] rq[$], re;
  logic [18:0] oq[$], oe;
  logic [24:0] yq[$], ye;
  int mismatches, check_count, seed, i, x, y, ew, eh, sx, sy, d, pw, lf, ctl, r, g, b, cb, cr;
  ifr_format_top #(.XB(4), .YB(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .in_sof(in_sof), .in_eol(in_eol), .in_eof(in_eof),
    .out_valid(out_valid), .out_data(out_data), .out_sof(out_sof), .out_eol(out_eol),
    .out_eof(out_eof), .rgb_valid(rgb_valid), .rgb_sol(rgb_sol), .rgb_r(rgb_r),
    .rgb_g(rgb_g), .rgb_b(rgb_b), .yc_valid(yc_valid), .yc_chroma_valid(yc_chroma_valid),
    .yc_y(yc_y), .yc_cb(yc_cb), .yc_cr(yc_cr));
  ifr_sensor_model u_sensor (.pclk(pclk), .start(start), .fw(fw), .fh(fh), .base(base),
    .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data), .in_sof(in_sof),
    .in_eol(in_eol), .in_eof(in_eof), .busy(busy));
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One APB transfer; an idle cycle follows so no signal is driven twice at one edge
  task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] wd,
    input logic [32:0] ex);
    int n;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
    if (!w) rq.push_back(ex);
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin mismatches++; finish_test(); end
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin @(negedge pclk); n++; end
    while ((busy || oq.size() || yq.size() || in_ready !== 1'b1) && n < 500);
    if (n >= 500) begin mismatches++; finish_test(); end
    @(posedge pclk);
  endtask
  // Monitor samples settled outputs mid-cycle and pops the oldest note
  always @(negedge pclk) begin
    if (psel && penable && !pwrite) begin
      re = rq.size() ? rq.pop_front() : 33'h1_ffff_ffff;
      `CHK("register read", re, {pslverr, prdata})
    end
    if (out_valid === 1'b1) begin
      oe = oq.size() ? oq.pop_front() : 19'h7_ffff;
      `CHK("pixel", oe, {out_sof, out_eol, out_eof, out_data})
    end
    if (yc_valid === 1'b1) begin
      ye = yq.size() ? yq.pop_front() : 25'h1ff_ffff;
      if (ye[24]) `CHK("colour", ye, {yc_chroma_valid, yc_y, yc_cb, yc_cr})
      else `CHK("luma", ye[24:16], {yc_chroma_valid, yc_y})
    end
  end
  initial begin
    repeat (30000) @(posedge pclk);
    mismatches++;
    finish_test();
  end
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; start = 0;
    rgb_valid = 0; rgb_sol = 0; rgb_r = 0; rgb_g = 0; rgb_b = 0; base = 0; fw = 5; fh = 3;
    mismatches = 0; check_count = 0; seed = 35;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    // Reset values, then an unmapped word answers with an error
    apb(0, 8'h00, 0, 33'h0_0000_1010);
    apb(0, 8'h10, 0, 33'h0_0000_ffff);
    apb(0, 8'h1c, 0, 33'h0);
    apb(0, 8'h20, 0, 33'h1_0000_0000);
    $display("test registers done");
    apb(1, 8'h0c, 1, 0);
    apb(1, 8'h10, 3, 0);
    apb(1, 8'h14, 9, 0);
    // Frames: depth, mirror, patterns and an empty window; loops outside run none
    for (i = 0; i < 7; i++) begin
      d = i % 3; pw = (i < 3) ? 12 : 16; lf = (i == 6) ? 5 : 1;
      ctl = (pw << 8) | (d << 4) | (i & 3);
      apb(1, 8'h00, ctl, 0);
      apb(1, 8'h04, (i >= 3 && i <= 5) ? 1 : 0, 0);
      // Increment choice is refused while the sensor generator is selected
      apb(1, 8'h04, 2, 0);
      apb(0, 8'h04, 0, 33'((i >= 3 && i <= 5) ? 1 : 0));
      apb(1, 8'h00, ctl | 4, 0);
      apb(1, 8'h04, (i == 4) ? 2 : 0, 0);
      apb(0, 8'h04, 0, 33'((i == 4) ? 2 : 0));
      apb(1, 8'h08, lf, 0);
      apb(0, 8'h1c, 0, 33'((i & 3) << 4));
      base = $random(seed);
      ew = fw - lf; if (ew > 3) ew = 3;
      eh = fh - 1; if (eh > 9) eh = 9;
      for (y = 0; y < eh; y++)
        for (x = 0; x < ew; x++) begin
          sx = i[0] ? fw - 1 - lf - x : lf + x;
          sy = i[1] ? fh - 2 - y : 1 + y;
          v = 16'(base + sy * 16 + sx);
          if (i >= 3 && i <= 5) v = 16'(sx + sy);
          v = (v & ((1 << (10 + 2 * d)) - 1)) << (6 - 2 * d);
          v = v & (16'hffff << (16 - pw));
          if (i == 4) v = {8'(sy * fw + sx), 8'h00};
          oq.push_back({x == 0 && y == 0, x == ew - 1, x == ew - 1 && y == eh - 1, v});
        end
      start <= 1;
      @(posedge pclk);
      start <= 0;
      wait_idle();
      apb(0, 8'h18, 0, {1'b0, 11'h0, fh, 11'h0, fw});
      $display("test frame %0d done", i);
    end
    // Colour line with extremes on chroma pixels, the blue and red ones saturating chroma
    for (i = 0; i < 12; i++) begin
      r = $random(seed) & 255; g = $random(seed) & 255; b = $random(seed) & 255;
      if (i == 0) begin r = 0; g = 0; b = 255; end
      if (i == 4) begin r = 255; g = 0; b = 0; end
      if (i == 8) begin r = 255; g = 255; b = 255; end
      rgb_valid <= 1; rgb_sol <= (i == 0); rgb_r <= 8'(r); rgb_g <= 8'(g); rgb_b <= 8'(b);
      cb = (32896 + 128 * b - 43 * r - 85 * g) >> 8; if (cb > 255) cb = 255;
      cr = (32896 + 128 * r - 107 * g - 21 * b) >> 8; if (cr > 255) cr = 255;
      yq.push_back({i % 4 == 0, 8'((77 * r + 150 * g + 29 * b) >> 8), 8'(cb), 8'(cr)});
      @(posedge pclk);
    end
    rgb_valid <= 0;
    wait_idle();
    $display("test colour done");
    finish_test();
  end
endmodule
`default_nettype wire
